// File: hw/batt_switch_pkg.sv
// batt_switch_pkg: constants, types and encodings for the battery switch sequencer.
// assumes one 100 MHz system clock and a 16-bit serial frame to the gate driver.
package batt_switch_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int MS_CYCLES       = CLK_HZ / 1000;
  localparam int SPI_CLK_HZ      = 5_000_000;
  localparam int SPI_HALF_CYCLES = CLK_HZ / (2 * SPI_CLK_HZ);
  localparam int SETTLE_MS       = 1;
  localparam logic [15:0] PRECHARGE_MS_RST = 16'h01f4;

  // ****************************************
  // driver register map
  // ****************************************
  localparam int NUM_REGS = 11;
  localparam logic [3:0] REG_GLOBAL_STATE  = 4'h0;
  localparam logic [3:0] REG_CHANNEL_FAULT = 4'h1;
  localparam logic [3:0] REG_DEVICE_CHECK  = 4'h2;
  localparam logic [3:0] REG_CHANNEL_CTRL  = 4'h3;
  localparam logic [3:0] REG_FAULT_CLEAR   = 4'h4;
  localparam logic [3:0] REG_DRAIN_LIMITS  = 4'h5;
  localparam logic [3:0] REG_FILTER_BLANK  = 4'h6;
  localparam logic [3:0] REG_SENSE_AMP     = 4'h7;
  localparam logic [3:0] REG_BATT_RESTART  = 4'h8;
  localparam logic [3:0] REG_RESET_CTRL    = 4'h9;
  localparam logic [3:0] REG_SPARE         = 4'ha;

  localparam int GLOBAL_FAIL_BIT        = 7;
  localparam int CHARGE_PUMP_OK_FLAG    = 6;
  localparam int SUPPLY_UNDERVOLTAGE_FLAG = 2;
  localparam int INTERLOCK_BIT          = 7;
  localparam int PRECHARGE_CHANNEL_ON_BIT = 3;
  localparam int MAIN_CHANNEL_ON_BIT    = 0;
  localparam logic [7:0] FAULT_CLEAR_ALL = 8'hbf;
  localparam int FRAME_WRITE_BIT        = 15;

  // ****************************************
  // field encodings, code to typical value
  // ****************************************
  localparam int OV_RESTART_US [4] = '{10, 50, 200, 1000};
  localparam int UV_RESTART_US [4] = '{1000, 5000, 20000, 50000};
  localparam int BLANK_US      [4] = '{10, 20, 50, 100};
  localparam int FILTER_NS     [4] = '{500, 1000, 2000, 5000};
  localparam int DRAIN_TH_MV   [8] = '{100, 150, 200, 250, 300, 400, 500, 600};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_ON, CMD_OFF, CMD_INIT, CMD_CLEAR, CMD_LOAD, CMD_PULSE_B, CMD_CH_A, CMD_FACTORY
  } cmd_t;

  typedef struct packed {
    logic [15:0] precharge_ms;
    logic [1:0]  uv_restart;
    logic [1:0]  ov_restart;
    logic [1:0]  blank_b;
    logic [1:0]  filter_b;
    logic [1:0]  blank_a;
    logic [1:0]  filter_a;
    logic        safe_b;
    logic [2:0]  drain_th_b;
    logic        safe_a;
    logic [2:0]  drain_th_a;
    logic        interlock;
    logic        sense_load;
    logic        sense_high;
    logic [1:0]  oc_thresh;
    logic [2:0]  amp_gain;
  } cfg_t;

  localparam cfg_t FACTORY_CFG = '{precharge_ms: PRECHARGE_MS_RST, uv_restart: 2'h0, ov_restart: 2'h0,
    blank_b: 2'h2, filter_b: 2'h2, blank_a: 2'h2, filter_a: 2'h2, safe_b: 1'b0, drain_th_b: 3'h3,
    safe_a: 1'b0, drain_th_a: 3'h3, interlock: 1'b1, sense_load: 1'b1, sense_high: 1'b0,
    oc_thresh: 2'h2, amp_gain: 3'h6};

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
  } change_t;

  typedef struct packed {
    logic [7:0] channel_faults;
    logic [7:0] global_flags;
  } fail_t;

endpackage : batt_switch_pkg

// File: hw/ms_timer.sv
// ms_timer: counts a number of milliseconds and pulses done at the end.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ms_timer
  import batt_switch_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        start_i,
  input  wire logic [15:0] ms_i,
  output logic             done_o
);
  localparam int CW = $clog2(CYC_PER_MS + 1);

  logic [CW-1:0] cyc_q;
  logic [15:0]   ms_q;
  logic          run_q;

  // ****************************************
  // count
  // ****************************************
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      run_q <= 1'b0;
      cyc_q <= '0;
      ms_q  <= 16'h0000;
    end else if (start_i) begin
      run_q <= 1'b1;
      cyc_q <= '0;
      ms_q  <= ms_i;
    end else if (run_q) begin
      if (ms_q == 16'h0000) begin
        run_q  <= 1'b0;
        done_o <= 1'b1;
      end else if (cyc_q == CW'(CYC_PER_MS - 1)) begin
        cyc_q <= '0;
        ms_q  <= ms_q - 16'h0001;
      end else begin
        cyc_q <= cyc_q + CW'(1);
      end
    end
  end

endmodule : ms_timer
`default_nettype wire

// File: hw/spi_frame.sv
// spi_frame: one 16-bit serial frame, msb first, data out on falling, in on rising edge.
// assumes the driver answers the addressed register in the last eight bits.
`timescale 1ns/1ps
`default_nettype none
module spi_frame
  import batt_switch_pkg::*;
#(
  parameter int HALF = SPI_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request
  input  wire logic        start_i,
  input  wire logic [15:0] tx_i,
  output logic             done_o,
  output logic [7:0]       rx_o,
  // pins
  output logic             sclk_o,
  output logic             csn_o,
  output logic             mosi_o,
  input  wire logic        miso_i
);
  localparam int CW = $clog2(HALF + 1);

  logic [CW-1:0] cnt_q;
  logic [3:0]    bit_q;
  logic [15:0]   sh_q;
  logic [15:0]   rsh_q;
  logic          miso_s1_q;
  logic          miso_s2_q;

  // ****************************************
  // pin sync
  // ****************************************
  always_ff @(posedge clk_i) begin
    miso_s1_q <= miso_i;
    miso_s2_q <= miso_s1_q;
  end

  // ****************************************
  // shifter
  // ****************************************
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      csn_o  <= 1'b1;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      cnt_q  <= '0;
      bit_q  <= 4'h0;
      sh_q   <= 16'h0000;
      rsh_q  <= 16'h0000;
      rx_o   <= 8'h00;
    end else if (csn_o) begin
      if (start_i) begin
        csn_o  <= 1'b0;
        sh_q   <= tx_i;
        mosi_o <= tx_i[15];
        cnt_q  <= '0;
        bit_q  <= 4'h0;
      end
    end else if (cnt_q == CW'(HALF - 1)) begin
      cnt_q <= '0;
      if (!sclk_o) begin
        sclk_o <= 1'b1;
        rsh_q  <= {rsh_q[14:0], miso_s2_q};
      end else begin
        sclk_o <= 1'b0;
        if (bit_q == 4'hf) begin
          csn_o  <= 1'b1;
          done_o <= 1'b1;
          rx_o   <= rsh_q[7:0];
        end else begin
          bit_q  <= bit_q + 4'h1;
          sh_q   <= {sh_q[14:0], 1'b0};
          mosi_o <= sh_q[14];
        end
      end
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : spi_frame
`default_nettype wire

// File: hw/batt_switch_seq.sv
// batt_switch_seq: on/off sequencing, setup image and register watch for the gate driver.
// assumes commands come from logic on the system clock; driver pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module batt_switch_seq
  import batt_switch_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES,
  parameter int SPI_HALF   = SPI_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  // command port
  input  wire logic        CMD_VALID_I,
  input  wire cmd_t        CMD_I,
  input  wire logic [15:0] PULSE_MS_I,
  output logic             CMD_READY_O,
  // setup image
  input  wire logic        CFG_WE_I,
  input  wire cfg_t        CFG_I,
  output cfg_t             CFG_O,
  // driver pins
  output logic             DRV_EN_O,
  output logic             SPI_SCLK_O,
  output logic             SPI_CSN_O,
  output logic             SPI_MOSI_O,
  input  wire logic        SPI_MISO_I,
  input  wire logic        DRV_INT_I,
  // status and reports
  output logic             CH_A_ON_O,
  output logic             CH_B_ON_O,
  output logic             CHG_VALID_O,
  output change_t          CHG_O,
  output logic             FAIL_VALID_O,
  output fail_t            FAIL_O
);

  typedef enum logic [10:0] {
    ST_IDLE     = 11'h001,
    ST_SETTLE   = 11'h002,
    ST_CLEAR    = 11'h004,
    ST_LOAD     = 11'h008,
    ST_PRE_ON   = 11'h010,
    ST_PRE_WAIT = 11'h020,
    ST_A_ON     = 11'h040,
    ST_OFF      = 11'h080,
    ST_DISABLE  = 11'h100,
    ST_POLL     = 11'h200,
    ST_XFER     = 11'h400
  } state_t;

  state_t      state_q;
  state_t      ret_q;
  cfg_t        cfg_q;
  logic        en_q;
  logic        chain_q;
  logic        go_on_q;
  logic        pulse_only_q;
  logic [15:0] pulse_ms_q;
  logic [2:0]  load_idx_q;
  logic [3:0]  poll_addr_q;
  logic        rd_q;
  logic [3:0]  rd_addr_q;
  logic        device_check_flags_pend_q;
  logic [7:0]  img_q [NUM_REGS];
  logic        int_s1_q;
  logic        int_s2_q;
  logic        int_s3_q;
  logic        take;
  logic        spi_start;
  logic [15:0] spi_tx;
  logic        spi_done;
  logic [7:0]  spi_rx;
  logic        tmr_start;
  logic [15:0] tmr_ms;
  logic        tmr_done;
  logic        int_rise;
  logic [7:0]  ctrl_base;
  logic [3:0]  load_addr;
  logic [7:0]  load_data;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] frame(input logic wr, input logic [3:0] a, input logic [7:0] d);
    return {wr, 3'h0, a, d};
  endfunction : frame

  assign take        = CMD_VALID_I && CMD_READY_O;
  assign CMD_READY_O = (state_q == ST_IDLE);
  assign CFG_O       = cfg_q;
  assign int_rise    = int_s2_q && !int_s3_q;
  // interlock kept in every channel write so no write drops it
  assign ctrl_base   = {cfg_q.interlock, 7'h00};

  // setup image packed into driver fields; codes go through unchanged
  always_comb begin
    load_addr = REG_CHANNEL_CTRL;
    load_data = ctrl_base;
    unique case (load_idx_q)
      3'h1: begin
        load_addr = REG_DRAIN_LIMITS;
        load_data = {cfg_q.safe_b, cfg_q.drain_th_b, cfg_q.safe_a, cfg_q.drain_th_a};
      end
      3'h2: begin
        load_addr = REG_FILTER_BLANK;
        load_data = {cfg_q.blank_b, cfg_q.filter_b, cfg_q.blank_a, cfg_q.filter_a};
      end
      3'h3: begin
        load_addr = REG_SENSE_AMP;
        load_data = {1'b0, cfg_q.sense_load, cfg_q.sense_high, cfg_q.oc_thresh, cfg_q.amp_gain};
      end
      3'h4: begin
        load_addr = REG_BATT_RESTART;
        load_data = {4'h0, cfg_q.uv_restart, cfg_q.ov_restart};
      end
      default: begin
        load_addr = REG_CHANNEL_CTRL;
        load_data = ctrl_base;
      end
    endcase
  end

  // ****************************************
  // interrupt pin sync
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    int_s1_q <= DRV_INT_I;
    int_s2_q <= int_s1_q;
    int_s3_q <= int_s2_q;
  end

  // ****************************************
  // setup image
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      cfg_q <= FACTORY_CFG;
    end else if (!en_q) begin
      // writable only while disabled, held while enabled, written out at the next setup
      if (take && CMD_I == CMD_FACTORY) begin
        cfg_q <= FACTORY_CFG;
      end else if (CFG_WE_I) begin
        cfg_q <= CFG_I;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    spi_start <= 1'b0;
    tmr_start <= 1'b0;
    if (RESET_I) begin
      state_q      <= ST_IDLE;
      ret_q        <= ST_IDLE;
      en_q         <= 1'b0;
      chain_q      <= 1'b0;
      go_on_q      <= 1'b0;
      pulse_only_q <= 1'b0;
      pulse_ms_q   <= 16'h0000;
      load_idx_q   <= 3'h0;
      poll_addr_q  <= 4'h0;
      rd_q         <= 1'b0;
      rd_addr_q    <= 4'h0;
      spi_tx       <= 16'h0000;
      tmr_ms       <= 16'h0000;
      CH_A_ON_O    <= 1'b0;
      CH_B_ON_O    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            unique case (CMD_I)
              CMD_ON, CMD_INIT: begin
                en_q       <= 1'b1;
                chain_q    <= 1'b1;
                go_on_q    <= (CMD_I == CMD_ON);
                pulse_ms_q <= cfg_q.precharge_ms;
                tmr_ms     <= 16'(SETTLE_MS);
                tmr_start  <= 1'b1;
                state_q    <= ST_SETTLE;
              end
              CMD_OFF: state_q <= en_q ? ST_OFF : ST_IDLE;
              CMD_CLEAR: begin
                chain_q <= 1'b0;
                state_q <= en_q ? ST_CLEAR : ST_IDLE;
              end
              CMD_LOAD: begin
                go_on_q    <= 1'b0;
                load_idx_q <= 3'h0;
                state_q    <= en_q ? ST_LOAD : ST_IDLE;
              end
              CMD_PULSE_B: begin
                pulse_only_q <= 1'b1;
                pulse_ms_q   <= PULSE_MS_I;
                state_q      <= en_q ? ST_PRE_ON : ST_IDLE;
              end
              CMD_CH_A: state_q <= en_q ? ST_A_ON : ST_IDLE;
              CMD_FACTORY: state_q <= ST_IDLE;
            endcase
          end else if (en_q) begin
            state_q <= ST_POLL;
          end
        end
        ST_SETTLE: begin
          // undervoltage flag from the fresh enable must show before it is cleared
          if (tmr_done) begin
            state_q <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          spi_tx     <= frame(1'b1, REG_FAULT_CLEAR, FAULT_CLEAR_ALL);
          spi_start  <= 1'b1;
          load_idx_q <= 3'h0;
          ret_q      <= chain_q ? ST_LOAD : ST_IDLE;
          state_q    <= ST_XFER;
        end
        ST_LOAD: begin
          spi_tx     <= frame(1'b1, load_addr, load_data);
          spi_start  <= 1'b1;
          load_idx_q <= load_idx_q + 3'h1;
          CH_A_ON_O  <= 1'b0;
          CH_B_ON_O  <= 1'b0;
          if (load_idx_q == 3'h4) begin
            pulse_only_q <= 1'b0;
            ret_q        <= go_on_q ? ST_PRE_ON : ST_IDLE;
          end else begin
            ret_q <= ST_LOAD;
          end
          state_q <= ST_XFER;
        end
        ST_PRE_ON: begin
          spi_tx    <= frame(1'b1, REG_CHANNEL_CTRL,
                             ctrl_base | 8'(1 << PRECHARGE_CHANNEL_ON_BIT)
                             | (CH_A_ON_O ? 8'(1 << MAIN_CHANNEL_ON_BIT) : 8'h00));
          spi_start <= 1'b1;
          CH_B_ON_O <= 1'b1;
          ret_q     <= ST_PRE_WAIT;
          state_q   <= ST_XFER;
        end
        ST_PRE_WAIT: begin
          if (tmr_done) begin
            spi_start <= 1'b1;
            CH_B_ON_O <= 1'b0;
            if (pulse_only_q) begin
              spi_tx <= frame(1'b1, REG_CHANNEL_CTRL,
                              ctrl_base | (CH_A_ON_O ? 8'(1 << MAIN_CHANNEL_ON_BIT) : 8'h00));
            end else begin
              spi_tx    <= frame(1'b1, REG_CHANNEL_CTRL, ctrl_base | 8'(1 << MAIN_CHANNEL_ON_BIT));
              CH_A_ON_O <= 1'b1;
            end
            pulse_only_q <= 1'b0;
            ret_q        <= ST_IDLE;
            state_q      <= ST_XFER;
          end
        end
        ST_A_ON: begin
          spi_tx    <= frame(1'b1, REG_CHANNEL_CTRL, ctrl_base | 8'(1 << MAIN_CHANNEL_ON_BIT)
                             | (CH_B_ON_O ? 8'(1 << PRECHARGE_CHANNEL_ON_BIT) : 8'h00));
          spi_start <= 1'b1;
          CH_A_ON_O <= 1'b1;
          ret_q     <= ST_IDLE;
          state_q   <= ST_XFER;
        end
        ST_OFF: begin
          spi_tx    <= frame(1'b1, REG_CHANNEL_CTRL, ctrl_base);
          spi_start <= 1'b1;
          CH_A_ON_O <= 1'b0;
          CH_B_ON_O <= 1'b0;
          ret_q     <= ST_DISABLE;
          state_q   <= ST_XFER;
        end
        ST_DISABLE: begin
          en_q    <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_POLL: begin
          spi_tx      <= frame(1'b0, poll_addr_q, 8'h00);
          spi_start   <= 1'b1;
          rd_q        <= 1'b1;
          rd_addr_q   <= poll_addr_q;
          poll_addr_q <= (poll_addr_q == 4'(NUM_REGS - 1)) ? 4'h0 : poll_addr_q + 4'h1;
          ret_q       <= ST_IDLE;
          state_q     <= ST_XFER;
        end
        ST_XFER: begin
          if (spi_done) begin
            rd_q    <= 1'b0;
            state_q <= ret_q;
            if (ret_q == ST_PRE_WAIT) begin
              tmr_ms    <= pulse_ms_q;
              tmr_start <= 1'b1;
            end
          end
          // a diagnosis request jumps the poll back to the global flags
          if (int_rise && !device_check_flags_pend_q) begin
            poll_addr_q <= REG_GLOBAL_STATE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // register watch and change report
  // ****************************************
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_img
      always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || !en_q) begin
          img_q[g] <= 8'h00;
        end else if (spi_done && rd_q && rd_addr_q == 4'(g)) begin
          img_q[g] <= spi_rx;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I) begin
    CHG_VALID_O <= 1'b0;
    if (RESET_I) begin
      CHG_O <= '0;
    end else if (spi_done && rd_q && spi_rx != img_q[rd_addr_q]) begin
      CHG_VALID_O    <= 1'b1;
      CHG_O.addr     <= rd_addr_q;
      CHG_O.set_bits <= spi_rx & ~img_q[rd_addr_q];
      CHG_O.clr_bits <= ~spi_rx & img_q[rd_addr_q];
    end
  end

  // ****************************************
  // failure report
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    FAIL_VALID_O <= 1'b0;
    if (RESET_I || !en_q) begin
      device_check_flags_pend_q <= 1'b0;
      FAIL_O      <= '0;
    end else if (spi_done && rd_q && rd_addr_q == REG_CHANNEL_FAULT && device_check_flags_pend_q) begin
      FAIL_VALID_O          <= 1'b1;
      FAIL_O.channel_faults <= spi_rx;
      FAIL_O.global_flags   <= img_q[REG_GLOBAL_STATE];
      device_check_flags_pend_q           <= int_rise;
    end else if (int_rise) begin
      device_check_flags_pend_q <= 1'b1;
    end else if (spi_done && rd_q && rd_addr_q == REG_GLOBAL_STATE && spi_rx[GLOBAL_FAIL_BIT]
                 && !img_q[REG_GLOBAL_STATE][GLOBAL_FAIL_BIT]) begin
      device_check_flags_pend_q <= 1'b1;
    end
  end

  // ****************************************
  // drivers and timer
  // ****************************************
  assign DRV_EN_O = en_q;

  spi_frame #(.HALF(SPI_HALF)) u_spi (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .start_i (spi_start),
    .tx_i    (spi_tx),
    .done_o  (spi_done),
    .rx_o    (spi_rx),
    .sclk_o  (SPI_SCLK_O),
    .csn_o   (SPI_CSN_O),
    .mosi_o  (SPI_MOSI_O),
    .miso_i  (SPI_MISO_I)
  );

  ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .start_i (tmr_start),
    .ms_i    (tmr_ms),
    .done_o  (tmr_done)
  );

endmodule : batt_switch_seq
`default_nettype wire

// File: verification/drv_model.sv
// drv_model: gate driver stand-in with eleven 8-bit registers behind a 16-bit frame
// assumes sclk idles low, data taken on rising and launched on falling edge
`timescale 1ns/1ps
`default_nettype none
module drv_model (
  // pins
  input  wire logic en_i,
  input  wire logic sclk_i,
  input  wire logic csn_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  output logic      int_o,
  output logic      bad_o
);
  logic [7:0]  regs [11];
  logic [15:0] sh;
  logic [4:0]  cnt;
  logic [3:0]  adr;
  initial {miso_o, int_o, bad_o, cnt} = 8'h00;
  // fresh enable: undervoltage and fail flags up, interrupt raised
  always @(posedge en_i) begin
    foreach (regs[k]) regs[k] = 8'h00;
    regs[0] = 8'hc4;
    int_o = 1'b1;
    #100 int_o = 1'b0;
  end
  always @(negedge csn_i) cnt = 5'h00;
  always @(posedge sclk_i) begin
    sh = {sh[14:0], mosi_i};
    cnt = cnt + 5'h01;
    if (cnt == 5'h08) adr = sh[3:0];
  end
  always @(negedge sclk_i) if (!csn_i && cnt >= 5'h08 && cnt < 5'h10) miso_o = regs[adr][15 - cnt];
  // released line shows the inverse, never the last bit
  always @(posedge csn_i) begin
    miso_o = ~miso_o;
    if (cnt == 5'h10 && sh[15] && sh[11:8] > 4'h2 && sh[11:8] < 4'hb) begin
      regs[sh[11:8]] = sh[7:0];
      if (sh[11:8] == 4'h4 && sh[2]) regs[0] = regs[0] & 8'h7b;
      if (sh[11:8] == 4'h3 && (sh[0] || sh[3]) && regs[0][2]) bad_o = 1'b1;
    end
  end
endmodule : drv_model
`default_nettype wire

// File: verification/batt_switch_seq_chk.sv
// checker: port assertions on the battery switch sequencer
// assumes it is bound into batt_switch_seq
`timescale 1ns/1ps
`default_nettype none
module batt_switch_seq_chk
  import batt_switch_pkg::*;
(
  // watched ports
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CMD_VALID_I,
  input wire cmd_t CMD_I,
  input wire logic CMD_READY_O,
  input wire logic CFG_WE_I,
  input wire cfg_t CFG_I,
  input wire cfg_t CFG_O,
  input wire logic DRV_EN_O,
  input wire logic SPI_CSN_O,
  input wire logic CH_A_ON_O,
  input wire logic CH_B_ON_O,
  input wire logic CHG_VALID_O,
  input wire logic FAIL_VALID_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  chg_pulse_a: assert property (CHG_VALID_O |=> !CHG_VALID_O) else $error("change pulse too long");
  fail_pulse_a: assert property (FAIL_VALID_O |=> !FAIL_VALID_O) else $error("fail pulse too long");
  chan_need_en_a: assert property (CH_A_ON_O || CH_B_ON_O |-> DRV_EN_O) else $error("channel on, driver off");
  enable_quiet_a: assert property ($rose(DRV_EN_O) |-> !CH_A_ON_O && !CH_B_ON_O ##1 SPI_CSN_O[*8])
    else $error("no settle after enable");
  a_after_b_a: assert property ($rose(CH_A_ON_O) |-> !CH_B_ON_O) else $error("channel a on during b");
  cfg_frozen_a: assert property (DRV_EN_O |=> $stable(CFG_O)) else $error("setup changed while on");
  cfg_write_a: assert property (CFG_WE_I && !DRV_EN_O |=> CFG_O == $past(CFG_I)) else $error("setup lost");
  on_enables_a: assert property (CMD_VALID_I && CMD_READY_O && CMD_I inside {CMD_ON, CMD_INIT}
    |=> DRV_EN_O && !CMD_READY_O) else $error("enable not first");
endmodule : batt_switch_seq_chk
bind batt_switch_seq batt_switch_seq_chk i_chk (.SYS_CLK_I, .RESET_I, .CMD_VALID_I, .CMD_I, .CMD_READY_O,
  .CFG_WE_I, .CFG_I, .CFG_O, .DRV_EN_O, .SPI_CSN_O, .CH_A_ON_O, .CH_B_ON_O, .CHG_VALID_O, .FAIL_VALID_O);
`default_nettype wire

// File: verification/batt_switch_seq_tb.sv
// batt_switch_seq_tb: command sequences against the sequencer and a driver stand-in
// assumes drv_model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module batt_switch_seq_tb;
  import batt_switch_pkg::*;
  logic clk, rst, vld, we, miso, irq, en, sclk, csn, mosi, rdy, cha, chb, chg_v, fail_v, bad;
  logic [15:0] ms;
  logic [7:0]  setb, clrb;
  cmd_t        cmd;
  cfg_t        cfg, cfg_q;
  change_t     chg;
  fail_t       fl;
  int          n_errors, checks, nfail, b_len;
  // short ms and fast link keep the run small
  batt_switch_seq #(.CYC_PER_MS(10), .SPI_HALF(4)) i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(vld),
    .CMD_I(cmd), .PULSE_MS_I(ms), .CMD_READY_O(rdy), .CFG_WE_I(we), .CFG_I(cfg), .CFG_O(cfg_q), .DRV_EN_O(en),
    .SPI_SCLK_O(sclk), .SPI_CSN_O(csn), .SPI_MOSI_O(mosi), .SPI_MISO_I(miso), .DRV_INT_I(irq), .CH_A_ON_O(cha),
    .CH_B_ON_O(chb), .CHG_VALID_O(chg_v), .CHG_O(chg), .FAIL_VALID_O(fail_v), .FAIL_O(fl));
  drv_model i_drv (.en_i(en), .sclk_i(sclk), .csn_i(csn), .mosi_i(mosi), .miso_o(miso), .int_o(irq), .bad_o(bad));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (chg_v && chg.addr === 4'h0) begin
      setb = setb | chg.set_bits;
      clrb = clrb | chg.clr_bits;
    end
    if (fail_v === 1'b1) nfail++;
    if (chb === 1'b1) b_len++;
  end
  task automatic cmp(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  // ready is steady from falling edge to the taking edge
  task automatic send(input cmd_t c, input logic [15:0] m);
    for (int i = 0; i < 3000 && rdy !== 1'b1; i++) @(negedge clk);
    if (rdy !== 1'b1) n_errors++;
    cmd = c;
    ms = m;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : send
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 20000 && s !== v; i++) @(negedge clk);
    if (s !== v) n_errors++;
  endtask : wait_for
  function automatic logic [31:0] enc(input cfg_t c);
    return {c.safe_b, c.drain_th_b, c.safe_a, c.drain_th_a, c.blank_b, c.filter_b, c.blank_a, c.filter_a,
      4'h0, c.uv_restart, c.ov_restart, 3'h0, c.oc_thresh, c.amp_gain};
  endfunction : enc
  function automatic logic [31:0] seen();
    return {i_drv.regs[5], i_drv.regs[6], i_drv.regs[8], 3'h0, i_drv.regs[7][4:0]};
  endfunction : seen
  task automatic close_out();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    #400_000;
    n_errors++;
    close_out();
  end
  initial begin
    {rst, vld, we, ms, setb, clrb, nfail, b_len} = {3'b100, 16'h0, 16'h0, 32'h0, 32'h0};
    cmd = CMD_OFF;
    cfg = FACTORY_CFG;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cmp("factory", {cfg_q.amp_gain, cfg_q.oc_thresh}, {3'h6, 2'h2});
    cfg = '{precharge_ms: 16'h0005, uv_restart: 2'h3, ov_restart: 2'h1, blank_b: 2'h1, filter_b: 2'h3,
      blank_a: 2'h0, filter_a: 2'h1, safe_b: 1'b1, drain_th_b: 3'h7, safe_a: 1'b0, drain_th_a: 3'h5,
      interlock: 1'b1, sense_load: 1'b1, sense_high: 1'b0, oc_thresh: 2'h3, amp_gain: 3'h1};
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    cmp("held cfg", cfg_q, cfg);
    send(CMD_ON, 16'h0);
    wait_for(cha, 1'b1);
    // channel frame still on the link when the shadow bit rises
    wait_for(rdy, 1'b1);
    cmp("loaded", seen(), enc(cfg));
    cmp("end state", {cha, chb, i_drv.regs[3][3], i_drv.regs[3][0], bad}, 5'b10010);
    cmp("precharge", b_len >= 50 && b_len <= 300, 1'b1);
    cfg.amp_gain = 3'h5;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    cmp("frozen", cfg_q.amp_gain, 3'h1);
    cfg.amp_gain = 3'h1;
    repeat (3000) @(negedge clk);
    {setb, clrb, nfail} = 48'h0;
    i_drv.regs[0] = 8'hd0;
    repeat (3000) @(negedge clk);
    i_drv.regs[0] = 8'h40;
    repeat (3000) @(negedge clk);
    cmp("changes", {setb, clrb}, 16'h9090);
    cmp("failure", {nfail != 0, fl.global_flags[7]}, 2'b11);
    send(CMD_OFF, 16'h0);
    wait_for(en, 1'b0);
    cmp("off", {cha, chb, en, i_drv.regs[3][3], i_drv.regs[3][0]}, 5'h0);
    send(CMD_FACTORY, 16'h0);
    cmp("factory cmd", cfg_q, FACTORY_CFG);
    cfg.drain_th_a = 3'h2;
    cfg.blank_a = 2'h3;
    cfg.uv_restart = 2'h2;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    send(CMD_INIT, 16'h0);
    for (int i = 0; i < 5000 && i_drv.regs[8] !== 8'h09; i++) @(negedge clk);
    repeat (20) @(negedge clk);
    cmp("reloaded", seen(), enc(cfg));
    cmp("init", {i_drv.regs[0], cha, chb}, 10'h100);
    b_len = 0;
    send(CMD_PULSE_B, 16'd20);
    wait_for(chb, 1'b1);
    wait_for(chb, 1'b0);
    cmp("pulse", b_len >= 200 && b_len <= 450, 1'b1);
    send(CMD_CH_A, 16'h0);
    wait_for(cha, 1'b1);
    wait_for(rdy, 1'b1);
    cmp("manual a", {cha, chb, i_drv.regs[3][0]}, 3'b101);
    i_drv.regs[5] = 8'h00;
    send(CMD_LOAD, 16'h0);
    wait_for(rdy, 1'b1);
    cmp("load cmd", seen(), enc(cfg));
    i_drv.regs[0] = 8'h44;
    send(CMD_CLEAR, 16'h0);
    wait_for(rdy, 1'b1);
    cmp("clear cmd", i_drv.regs[0], 8'h40);
    close_out();
  end
endmodule : batt_switch_seq_tb
`default_nettype wire
